// ===== trigger_step_pkg.sv
// Shared constants and types of the trigger step sequencer
package trigger_step_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and sizes
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int QUEUE_DEPTH = 32;
	localparam int PTR_W = 5;
	localparam int STEP_W = 8;
	localparam int TRIG_IN_N = 16;
	localparam int TRIG_OUT_N = 32;
	localparam int IRQ_N = 16;
	localparam int CHAN_W = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Step byte layout
	localparam int CMD_MSB = 7;
	localparam int CMD_LSB = 4;
	localparam int OPT_MSB = 3;
	localparam int OPT_LSB = 0;
	localparam int OPT_COPY_BIT = 3;

	// Command families, taken from command bits 3 to 1
	localparam logic [2:0] FAM_CTRL = 3'h0;
	localparam logic [2:0] FAM_STRB = 3'h1;
	localparam logic [2:0] FAM_WAIT = 3'h2;
	localparam logic [2:0] FAM_IRQ = 3'h3;
	localparam logic [2:0] FAM_TRIG = 3'h4;
	localparam logic [2:0] FAM_JMP = 3'h5;
	localparam logic [2:0] FAM_LOOP0 = 3'h6;
	localparam logic [2:0] FAM_LOOP1 = 3'h7;

	// Control action options
	localparam logic [3:0] OPT_NOP = 4'h0;
	localparam logic [3:0] OPT_STOP = 4'h1;
	localparam logic [3:0] OPT_CLR_C0 = 4'h2;
	localparam logic [3:0] OPT_CLR_C1 = 4'h3;

	// Add and copy targets
	localparam logic [2:0] TGT_LIMIT0 = 3'h0;
	localparam logic [2:0] TGT_LIMIT1 = 3'h1;
	localparam logic [2:0] TGT_HOLD = 3'h2;
	localparam logic [2:0] TGT_ADJUST = 3'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [2:0] QUEUE_PAGE = 3'h0;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_STATE = 8'h21;
	localparam logic [7:0] OFS_ADJUST = 8'h22;
	localparam logic [7:0] OFS_HOLD = 8'h23;
	localparam logic [7:0] OFS_LIMIT0 = 8'h24;
	localparam logic [7:0] OFS_LIMIT1 = 8'h25;
	localparam logic [7:0] OFS_COUNT0 = 8'h26;
	localparam logic [7:0] OFS_COUNT1 = 8'h27;
	localparam logic [7:0] OFS_QPTR = 8'h28;
	localparam logic [7:0] OFS_CHAN = 8'h29;
	localparam logic [7:0] OFS_INT_STAT = 8'h2A;
	localparam logic [7:0] OFS_INT_MASK = 8'h2B;

	// Register field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int STATE_RUN_BIT = 0;
	localparam int STATE_WAIT_BIT = 1;
	localparam int STATE_PTR_LSB = 8;

	// Reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [4:0] RST_PTR = 5'h00;
	localparam logic [4:0] RST_CHAN = 5'h00;
	localparam logic [7:0] RST_STEP = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_WAIT
	} seq_state_t;

endpackage : trigger_step_pkg

// ===== step_queue.sv
// Flip-flop store of the step queue with one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module step_queue (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [4:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [4:0] i_exec_addr,
	input wire logic [4:0] i_bus_addr,
	output logic [7:0] o_exec_data,
	output logic [7:0] o_bus_data
);

	logic [7:0] mem_ff [trigger_step_pkg::QUEUE_DEPTH];

	// Entries reset to a control no-operation step
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < trigger_step_pkg::QUEUE_DEPTH; i++) begin
				mem_ff[i] <= trigger_step_pkg::RST_STEP;
			end
		end else if (i_we) begin
			mem_ff[i_waddr] <= i_wdata;
		end
	end

	// Read ports are plain index selects
	assign o_exec_data = mem_ff[i_exec_addr];
	assign o_bus_data = mem_ff[i_bus_addr];

endmodule : step_queue
`default_nettype wire

// ===== trigger_edge_detect.sv
// Registered rising and falling edge pulses of the trigger inputs
`timescale 1ns/1ps
`default_nettype none
module trigger_edge_detect (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_level,
	output logic [15:0] o_rise,
	output logic [15:0] o_fall
);

	logic [15:0] prev_ff;
	logic [15:0] rise_ff;
	logic [15:0] fall_ff;

	// Previous level and one-cycle edge pulses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_ff <= trigger_step_pkg::RST_WORD;
			rise_ff <= trigger_step_pkg::RST_WORD;
			fall_ff <= trigger_step_pkg::RST_WORD;
		end else begin
			prev_ff <= i_level;
			rise_ff <= i_level & ~prev_ff;
			fall_ff <= ~i_level & prev_ff;
		end
	end

	assign o_rise = rise_ff;
	assign o_fall = fall_ff;

endmodule : trigger_edge_detect
`default_nettype wire

// ===== trigger_step_sequencer_decoder.sv
// Step queue command decoder and executor with its register port
//
// How it works
// - Step byte: command high nibble, option low
// - Code 0000 runs the selected control action
// - Code 0001 adds adjust value to target
// - Copy variant loads hold value into target
// - Codes 001x load the ADC channel select
// - Code 0100 waits for selected rising edge
// - Code 0101 waits for selected falling edge
// - Code 0111 raises the selected interrupt request
// - Codes 100x pulse the selected trigger output
// - Codes 101x load queue pointer and jump
// - Codes 110x loop on first counter and limit
// - Codes 111x loop on second counter and limit
// - Reserved codes and options are consumed as no-operation
`timescale 1ns/1ps
`default_nettype none
module trigger_step_sequencer_decoder (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_trig_in,
	output logic [15:0] o_rdata,
	output logic o_irq,
	output logic [15:0] o_irq_req,
	output logic [31:0] o_trig,
	output logic [4:0] o_adc_channel_select
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	trigger_step_pkg::seq_state_t state_ff;
	trigger_step_pkg::seq_state_t nxt_state;
	logic [4:0] ptr_ff;
	logic [4:0] nxt_ptr;
	logic run_ff;
	logic [15:0] adjust_ff;
	logic [15:0] hold_ff;
	logic [15:0] limit0_ff;
	logic [15:0] limit1_ff;
	logic [15:0] count0_ff;
	logic [15:0] count1_ff;
	logic [15:0] int_stat_ff;
	logic [15:0] int_mask_ff;
	logic [4:0] chan_ff;
	logic [31:0] trig_ff;
	logic [15:0] irq_req_ff;
	logic irq_ff;
	logic [15:0] rdata_ff;

	logic [7:0] step;
	logic [7:0] bus_step;
	logic [3:0] cmd;
	logic [3:0] opt;
	logic [4:0] dest;
	logic [15:0] rise;
	logic [15:0] fall;
	logic wait_hit;

	logic [15:0] irq_set;
	logic [31:0] trig_pulse;
	logic chan_we;
	logic tgt_we;
	logic [2:0] tgt_sel;
	logic [15:0] tgt_val;
	logic c0_inc;
	logic c1_inc;
	logic c0_clr;
	logic c1_clr;
	logic stop;

	logic queue_hit;
	logic wr_ctrl;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Five-bit operand from command bit 0 and the option field
	function automatic logic [4:0] step_operand(input logic [3:0] c, input logic [3:0] o);
		step_operand = {c[0], o};
	endfunction : step_operand

	// Current contents of an add or copy target
	function automatic logic [15:0] target_value(input logic [2:0] sel,
		input logic [15:0] l0, input logic [15:0] l1,
		input logic [15:0] h, input logic [15:0] a);
		case (sel)
			trigger_step_pkg::TGT_LIMIT0: target_value = l0;
			trigger_step_pkg::TGT_LIMIT1: target_value = l1;
			trigger_step_pkg::TGT_HOLD: target_value = h;
			trigger_step_pkg::TGT_ADJUST: target_value = a;
			default: target_value = trigger_step_pkg::RST_WORD;
		endcase
	endfunction : target_value

	////////////////////////////////////////////////////////////////////////////////
	// Queue store and trigger input edges
	assign queue_hit = (i_addr[7:5] == trigger_step_pkg::QUEUE_PAGE);
	assign wr_ctrl = i_wr && (i_addr == trigger_step_pkg::OFS_CTRL);

	step_queue u_queue (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(i_wr && queue_hit),
		.i_waddr(i_addr[4:0]),
		.i_wdata(i_wdata[7:0]),
		.i_exec_addr(ptr_ff),
		.i_bus_addr(i_addr[4:0]),
		.o_exec_data(step),
		.o_bus_data(bus_step)
	);

	trigger_edge_detect u_edges (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(i_trig_in),
		.o_rise(rise),
		.o_fall(fall)
	);

	// Split of the step byte into command and option
	assign cmd = step[trigger_step_pkg::CMD_MSB:trigger_step_pkg::CMD_LSB];
	assign opt = step[trigger_step_pkg::OPT_MSB:trigger_step_pkg::OPT_LSB];
	assign dest = step_operand(cmd, opt);

	// Edge selected by a pending wait step
	assign wait_hit = cmd[0] ? fall[opt] : rise[opt];

	////////////////////////////////////////////////////////////////////////////////
	// Step decode and sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_ptr = ptr_ff;
		irq_set = '0;
		trig_pulse = '0;
		chan_we = 1'b0;
		tgt_we = 1'b0;
		tgt_sel = opt[2:0];
		tgt_val = trigger_step_pkg::RST_WORD;
		c0_inc = 1'b0;
		c1_inc = 1'b0;
		c0_clr = 1'b0;
		c1_clr = 1'b0;
		stop = 1'b0;
		case (state_ff)
			trigger_step_pkg::SEQ_IDLE: begin
				if (run_ff) begin
					nxt_state = trigger_step_pkg::SEQ_RUN;
				end
			end
			trigger_step_pkg::SEQ_RUN: begin
				if (!run_ff) begin
					nxt_state = trigger_step_pkg::SEQ_IDLE;
				end else begin
					nxt_ptr = ptr_ff + 5'h01;
					case (cmd[3:1])
						trigger_step_pkg::FAM_CTRL: begin
							if (!cmd[0]) begin
								case (opt)
									trigger_step_pkg::OPT_STOP: begin
										stop = 1'b1;
										nxt_state = trigger_step_pkg::SEQ_IDLE;
									end
									trigger_step_pkg::OPT_CLR_C0: c0_clr = 1'b1;
									trigger_step_pkg::OPT_CLR_C1: c1_clr = 1'b1;
									default: ;
								endcase
							end else if (opt[2:0] <= trigger_step_pkg::TGT_ADJUST) begin
								tgt_we = 1'b1;
								if (opt[trigger_step_pkg::OPT_COPY_BIT]) begin
									tgt_val = hold_ff;
								end else begin
									tgt_val = target_value(opt[2:0], limit0_ff, limit1_ff,
										hold_ff, adjust_ff) + adjust_ff;
								end
							end
						end
						trigger_step_pkg::FAM_STRB: chan_we = 1'b1;
						trigger_step_pkg::FAM_WAIT: begin
							nxt_ptr = ptr_ff;
							nxt_state = trigger_step_pkg::SEQ_WAIT;
						end
						trigger_step_pkg::FAM_IRQ: begin
							if (cmd[0]) begin
								irq_set[opt] = 1'b1;
							end
						end
						trigger_step_pkg::FAM_TRIG: trig_pulse[dest] = 1'b1;
						trigger_step_pkg::FAM_JMP: nxt_ptr = dest;
						trigger_step_pkg::FAM_LOOP0: begin
							if (count0_ff != limit0_ff) begin
								c0_inc = 1'b1;
								nxt_ptr = dest;
							end
						end
						trigger_step_pkg::FAM_LOOP1: begin
							if (count1_ff != limit1_ff) begin
								c1_inc = 1'b1;
								nxt_ptr = dest;
							end
						end
						default: ;
					endcase
				end
			end
			trigger_step_pkg::SEQ_WAIT: begin
				if (!run_ff) begin
					nxt_state = trigger_step_pkg::SEQ_IDLE;
				end else if (wait_hit) begin
					nxt_ptr = ptr_ff + 5'h01;
					nxt_state = trigger_step_pkg::SEQ_RUN;
				end
			end
			default: nxt_state = trigger_step_pkg::SEQ_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= trigger_step_pkg::SEQ_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Run enable; a stop step outranks a software write
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_ff <= 1'b0;
		end else if (stop) begin
			run_ff <= 1'b0;
		end else if (wr_ctrl) begin
			run_ff <= i_wdata[trigger_step_pkg::CTRL_RUN_BIT];
		end
	end

	// Queue pointer; software restart or load outranks sequencing
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ptr_ff <= trigger_step_pkg::RST_PTR;
		end else if (wr_ctrl && i_wdata[trigger_step_pkg::CTRL_RESTART_BIT]) begin
			ptr_ff <= trigger_step_pkg::RST_PTR;
		end else if (i_wr && (i_addr == trigger_step_pkg::OFS_QPTR)) begin
			ptr_ff <= i_wdata[4:0];
		end else begin
			ptr_ff <= nxt_ptr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Value registers; step writes outrank software writes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			adjust_ff <= trigger_step_pkg::RST_WORD;
			hold_ff <= trigger_step_pkg::RST_WORD;
			limit0_ff <= trigger_step_pkg::RST_WORD;
			limit1_ff <= trigger_step_pkg::RST_WORD;
		end else begin
			if (tgt_we && tgt_sel == trigger_step_pkg::TGT_ADJUST) begin
				adjust_ff <= tgt_val;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_ADJUST) begin
				adjust_ff <= i_wdata;
			end
			if (tgt_we && tgt_sel == trigger_step_pkg::TGT_HOLD) begin
				hold_ff <= tgt_val;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_HOLD) begin
				hold_ff <= i_wdata;
			end
			if (tgt_we && tgt_sel == trigger_step_pkg::TGT_LIMIT0) begin
				limit0_ff <= tgt_val;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_LIMIT0) begin
				limit0_ff <= i_wdata;
			end
			if (tgt_we && tgt_sel == trigger_step_pkg::TGT_LIMIT1) begin
				limit1_ff <= tgt_val;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_LIMIT1) begin
				limit1_ff <= i_wdata;
			end
		end
	end

	// Loop counters
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count0_ff <= trigger_step_pkg::RST_WORD;
			count1_ff <= trigger_step_pkg::RST_WORD;
		end else begin
			if (c0_clr) begin
				count0_ff <= trigger_step_pkg::RST_WORD;
			end else if (c0_inc) begin
				count0_ff <= count0_ff + 16'h0001;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_COUNT0) begin
				count0_ff <= i_wdata;
			end
			if (c1_clr) begin
				count1_ff <= trigger_step_pkg::RST_WORD;
			end else if (c1_inc) begin
				count1_ff <= count1_ff + 16'h0001;
			end else if (i_wr && i_addr == trigger_step_pkg::OFS_COUNT1) begin
				count1_ff <= i_wdata;
			end
		end
	end

	// ADC channel select
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			chan_ff <= trigger_step_pkg::RST_CHAN;
		end else if (chan_we) begin
			chan_ff <= dest;
		end else if (i_wr && i_addr == trigger_step_pkg::OFS_CHAN) begin
			chan_ff <= i_wdata[4:0];
		end
	end

	// One-cycle trigger and interrupt request pulses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			trig_ff <= '0;
			irq_req_ff <= trigger_step_pkg::RST_WORD;
		end else begin
			trig_ff <= trig_pulse;
			irq_req_ff <= irq_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and line; a new request beats a clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_stat_ff <= trigger_step_pkg::RST_WORD;
		end else if (i_wr && i_addr == trigger_step_pkg::OFS_INT_STAT) begin
			int_stat_ff <= (int_stat_ff & ~i_wdata) | irq_set;
		end else begin
			int_stat_ff <= int_stat_ff | irq_set;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_mask_ff <= trigger_step_pkg::RST_WORD;
		end else if (i_wr && i_addr == trigger_step_pkg::OFS_INT_MASK) begin
			int_mask_ff <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(int_stat_ff & int_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after a read strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= trigger_step_pkg::RST_WORD;
		end else if (!i_rd) begin
			rdata_ff <= trigger_step_pkg::RST_WORD;
		end else if (queue_hit) begin
			rdata_ff <= {8'h00, bus_step};
		end else begin
			case (i_addr)
				trigger_step_pkg::OFS_CTRL: rdata_ff <= {15'h0000, run_ff};
				trigger_step_pkg::OFS_STATE: rdata_ff <= {3'h0, ptr_ff, 6'h00,
					(state_ff == trigger_step_pkg::SEQ_WAIT),
					(state_ff != trigger_step_pkg::SEQ_IDLE)};
				trigger_step_pkg::OFS_ADJUST: rdata_ff <= adjust_ff;
				trigger_step_pkg::OFS_HOLD: rdata_ff <= hold_ff;
				trigger_step_pkg::OFS_LIMIT0: rdata_ff <= limit0_ff;
				trigger_step_pkg::OFS_LIMIT1: rdata_ff <= limit1_ff;
				trigger_step_pkg::OFS_COUNT0: rdata_ff <= count0_ff;
				trigger_step_pkg::OFS_COUNT1: rdata_ff <= count1_ff;
				trigger_step_pkg::OFS_QPTR: rdata_ff <= {11'h000, ptr_ff};
				trigger_step_pkg::OFS_CHAN: rdata_ff <= {11'h000, chan_ff};
				trigger_step_pkg::OFS_INT_STAT: rdata_ff <= int_stat_ff;
				trigger_step_pkg::OFS_INT_MASK: rdata_ff <= int_mask_ff;
				default: rdata_ff <= trigger_step_pkg::RST_WORD;
			endcase
		end
	end

	// Outputs straight from flip-flops
	assign o_rdata = rdata_ff;
	assign o_irq = irq_ff;
	assign o_irq_req = irq_req_ff;
	assign o_trig = trig_ff;
	assign o_adc_channel_select = chan_ff;

endmodule : trigger_step_sequencer_decoder
`default_nettype wire

// ===== step_decoder_props.sv
// Port-level checker of the trigger step sequencer decoder
`timescale 1ns/1ps
`default_nettype none
module step_decoder_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_trig_in,
	input wire logic [15:0] o_rdata,
	input wire logic o_irq,
	input wire logic [15:0] o_irq_req,
	input wire logic [31:0] o_trig,
	input wire logic [4:0] o_adc_channel_select
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////////////////////
	// Step effects seen at the outputs
	property p_trig_onehot;
		$onehot0(o_trig);
	endproperty
	property p_irq_onehot;
		$onehot0(o_irq_req);
	endproperty
	property p_one_step;
		o_trig != 32'h0 |-> o_irq_req == 16'h0;
	endproperty
	property p_chan_alone;
		$changed(o_adc_channel_select) && !$past(i_wr) |-> o_trig == 32'h0 && o_irq_req == 16'h0;
	endproperty
	a_trig_onehot: assert property (p_trig_onehot) else $error("trigger pulse not single");
	a_irq_onehot: assert property (p_irq_onehot) else $error("irq request not single");
	a_one_step: assert property (p_one_step) else $error("two step effects at once");
	a_chan_alone: assert property (p_chan_alone) else $error("channel load with pulse");

	////////////////////////////////////////////////////////////////////////////////
	// Register port behaviour
	property p_queue_byte;
		i_rd && i_addr < 8'h20 |=> o_rdata[15:8] == 8'h00;
	endproperty
	property p_queue_readback;
		(i_wr && i_addr < 8'h20) ##1 !i_wr ##1 (i_rd && i_addr == $past(i_addr, 2))
			|=> o_rdata == {8'h00, $past(i_wdata[7:0], 3)};
	endproperty
	property p_rdata_quiet;
		!$past(i_rd) |-> o_rdata == 16'h0000;
	endproperty
	property p_unmapped;
		i_rd && i_addr > 8'h2B |=> o_rdata == 16'h0000;
	endproperty
	property p_mask_off;
		(i_wr && i_addr == 8'h2B && i_wdata == 16'h0000) ##1 !(i_wr && i_addr == 8'h2B)
			|=> !o_irq;
	endproperty
	a_queue_byte: assert property (p_queue_byte) else $error("queue entry wider than a byte");
	a_queue_readback: assert property (p_queue_readback) else $error("queue entry lost");
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside its cycle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_mask_off: assert property (p_mask_off) else $error("masked interrupt still high");

	// Main scenarios reached
	c_trig: cover property (o_trig != 32'h0);
	c_irq_req: cover property (o_irq_req != 16'h0);
	c_irq: cover property ($rose(o_irq));
endmodule : step_decoder_props

bind trigger_step_sequencer_decoder step_decoder_props i_step_decoder_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .i_trig_in(i_trig_in), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_irq_req(o_irq_req), .o_trig(o_trig), .o_adc_channel_select(o_adc_channel_select)
);
`default_nettype wire

// ===== trigger_peer_model.sv
// Far-side model: drives trigger input levels and records trigger pulses
`timescale 1ns/1ps
`default_nettype none
module trigger_peer_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_level,
	input wire logic i_clear,
	input wire logic [31:0] i_trig,
	output logic [15:0] o_trig_in,
	output logic [31:0] o_seen,
	output logic [7:0] o_pulses
);
	// Trigger sources change only on the clock, as on-chip logic would
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_trig_in <= 16'h0000;
		end else begin
			o_trig_in <= i_level;
		end
	end

	// Sticky record and count of received trigger pulses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_seen <= 32'h0;
			o_pulses <= 8'h00;
		end else if (i_clear) begin
			o_seen <= 32'h0;
			o_pulses <= 8'h00;
		end else begin
			o_seen <= o_seen | i_trig;
			o_pulses <= o_pulses + 8'($countones(i_trig));
		end
	end
endmodule : trigger_peer_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the trigger step sequencer decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	logic i_clk, i_rst, i_wr, i_rd, peer_clear;
	logic [7:0] i_addr;
	logic [15:0] i_wdata, i_trig_in, o_rdata, o_irq_req, peer_level;
	logic o_irq;
	logic [31:0] o_trig, peer_seen;
	logic [4:0] o_adc_channel_select;
	logic [7:0] peer_pulses;
	logic [15:0] req_seen;
	int bad_count = 0;
	int checked = 0;

	trigger_step_sequencer_decoder i_trigger_step_sequencer_decoder (.i_clk(i_clk),
		.i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_trig_in(i_trig_in), .o_rdata(o_rdata), .o_irq(o_irq), .o_irq_req(o_irq_req),
		.o_trig(o_trig), .o_adc_channel_select(o_adc_channel_select));
	trigger_peer_model i_trigger_peer_model (.i_clk(i_clk), .i_rst(i_rst), .i_level(peer_level),
		.i_clear(peer_clear), .i_trig(o_trig), .o_trig_in(i_trig_in), .o_seen(peer_seen),
		.o_pulses(peer_pulses));

	// Sticky record of interrupt request pulses, cleared with the peer record
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			req_seen <= 16'h0000;
		end else if (peer_clear) begin
			req_seen <= 16'h0000;
		end else begin
			req_seen <= req_seen | o_irq_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles and helpers
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	// Step k of the queue is byte k of q, lowest byte first
	task automatic load(input logic [63:0] q, input int n);
		logic [15:0] d;
		for (int k = 0; k < n; k++) begin
			wr(8'(k), {8'h00, q[8*k +: 8]});
			rd(8'(k), d);
			`CHK(d, {8'h00, q[8*k +: 8]})
		end
	endtask : load
	task automatic clr_peer();
		@(posedge i_clk);
		peer_clear <= 1'b1;
		@(posedge i_clk);
		peer_clear <= 1'b0;
	endtask : clr_peer
	// Restart from step 0 and poll until the stop step ends the run
	task automatic run_wait(input int lim);
		logic [15:0] d;
		wr(trigger_step_pkg::OFS_CTRL, 16'h0003);
		d = 16'h0001;
		for (int n = 0; n < lim && d[0] === 1'b1; n++) rd(trigger_step_pkg::OFS_STATE, d);
		`CHK(d[0], 1'b0)
	endtask : run_wait
	task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask : chk_reg

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int a = 8'h1F; a <= 8'h30; a++) chk_reg(8'(a), 16'h0000);
		wr(8'h30, 16'hFFFF);
		chk_reg(8'h30, 16'h0000);
	endtask : t_reset
	task automatic t_actions();
		clr_peer();
		load(64'h0000_0001_723A_9385, 5);
		run_wait(50);
		`CHK(peer_seen, 32'h0008_0020)
		`CHK(peer_pulses, 8'h02)
		`CHK(req_seen, 16'h0004)
		`CHK(o_adc_channel_select, 5'h1A)
		chk_reg(trigger_step_pkg::OFS_INT_STAT, 16'h0004);
		chk_reg(trigger_step_pkg::OFS_STATE, 16'h0500);
		`CHK(o_irq, 1'b0)
		wr(trigger_step_pkg::OFS_INT_MASK, 16'h0004);
		repeat (2) @(posedge i_clk);
		#1 `CHK(o_irq, 1'b1)
		wr(trigger_step_pkg::OFS_INT_STAT, 16'h0004);
		repeat (2) @(posedge i_clk);
		#1 `CHK(o_irq, 1'b0)
		wr(trigger_step_pkg::OFS_INT_MASK, 16'h0000);
	endtask : t_actions
	task automatic t_math();
		wr(trigger_step_pkg::OFS_ADJUST, 16'h0003);
		wr(trigger_step_pkg::OFS_HOLD, 16'h0010);
		wr(trigger_step_pkg::OFS_LIMIT0, 16'h0005);
		load(64'h0001_0460_1C19_1010, 7);
		run_wait(50);
		`CHK(req_seen, 16'h0004)
		chk_reg(trigger_step_pkg::OFS_LIMIT0, 16'h000B);
		chk_reg(trigger_step_pkg::OFS_LIMIT1, 16'h0010);
		chk_reg(trigger_step_pkg::OFS_ADJUST, 16'h0003);
		chk_reg(trigger_step_pkg::OFS_STATE, 16'h0700);
	endtask : t_math
	task automatic t_loop();
		wr(trigger_step_pkg::OFS_LIMIT0, 16'h0002);
		wr(trigger_step_pkg::OFS_LIMIT1, 16'h0001);
		wr(trigger_step_pkg::OFS_COUNT0, 16'h0005);
		clr_peer();
		load(64'h0001_81A6_E1C1_8002, 7);
		run_wait(80);
		`CHK(peer_pulses, 8'h04)
		`CHK(peer_seen, 32'h0000_0001)
		chk_reg(trigger_step_pkg::OFS_COUNT0, 16'h0002);
		chk_reg(trigger_step_pkg::OFS_COUNT1, 16'h0001);
		chk_reg(trigger_step_pkg::OFS_STATE, 16'h0700);
	endtask : t_loop
	task automatic t_wait();
		clr_peer();
		load(64'h0000_0181_5380_4303, 6);
		wr(trigger_step_pkg::OFS_CTRL, 16'h0003);
		repeat (10) @(posedge i_clk);
		chk_reg(trigger_step_pkg::OFS_STATE, 16'h0103);
		chk_reg(trigger_step_pkg::OFS_COUNT1, 16'h0000);
		peer_level <= 16'h0004;
		repeat (6) @(posedge i_clk);
		`CHK(peer_pulses, 8'h00)
		peer_level <= 16'h000C;
		repeat (8) @(posedge i_clk);
		`CHK(peer_seen, 32'h0000_0001)
		peer_level <= 16'h0004;
		repeat (8) @(posedge i_clk);
		`CHK(peer_seen, 32'h0000_0003)
		chk_reg(trigger_step_pkg::OFS_STATE, 16'h0600);
	endtask : t_wait

	////////////////////////////////////////////////////////////////////////////////
	// Clock, sequence, watchdog and verdict
	task automatic stop_test();
		if (bad_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 16'h0000;
		peer_level = 16'h0000;
		peer_clear = 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_actions();
		t_math();
		t_loop();
		t_wait();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
